// [inc/status_pkg.sv]
package status_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] EVENT_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // control fields
  localparam int CTRL_PENDANTLESS = 0;
  localparam int CTRL_FAILURE = 1;
  localparam int CTRL_CODE_LSB = 16;
  // event bits, write one to pulse
  localparam int EVT_MOTOR_ON = 0;
  localparam int EVT_MOTOR_OFF = 1;
  localparam int EVT_CAL_OK = 2;
  localparam int EVT_CAL_FAIL = 3;
  localparam int EVT_RUN = 4;
  localparam int EVT_END = 5;
  localparam int EVT_PANEL_STOP = 6;
  localparam int EVT_IDLE = 7;
  localparam int EVT_EXT_ON = 8;
  localparam int EVT_EXT_OFF = 9;
  localparam int EVT_WIDTH = 10;
  // status bits
  localparam int ST_SERVO = 0;
  localparam int ST_CAL = 1;
  localparam int ST_EXT = 2;
  localparam int ST_TEACH = 3;
  localparam int ST_ACK = 4;
  localparam int ST_INOP = 5;
  localparam int ST_CEND = 6;
  localparam int ST_CPU = 7;
  localparam int ST_AUTO = 8;
  localparam int ST_CAL_PEND = 9;
  localparam int ST_START_PEND = 10;
  // mode selector codes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_TEACH = 2'h2;
  // failure codes whose servo drop is limited to external auto mode
  localparam logic [15:0] CODE_A_LO = 16'h6071;
  localparam logic [15:0] CODE_A_HI = 16'h607B;
  localparam logic [15:0] CODE_B_LO = 16'h6671;
  localparam logic [15:0] CODE_B_HI = 16'h667B;
  localparam logic [15:0] CODE_SINGLE = 16'h607F;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int PIN_COUNT = 14;
endpackage

// [src/pin_sync.sv]
`timescale 1ns/10ps
// two-stage synchroniser; no reset so that the health level passes through reset
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge core_clk) begin
    meta_r <= async_in;
    sync_r <= meta_r;
  end

  assign sync_out = sync_r;
endmodule

// [src/system_status_output_logic.sv]
`timescale 1ns/10ps
module system_status_output_logic (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic motor_power_request,
  input wire logic calibration_request,
  input wire logic external_mode_request,
  input wire logic prep_strobe,
  input wire logic robot_stop,
  input wire logic auto_enable,
  input wire logic program_start_request,
  input wire logic all_inst_stop,
  input wire logic all_step_stop,
  input wire logic [1:0] panel_mode,
  input wire logic [1:0] pendant_mode,
  input wire logic cpu_health,
  output logic servo_on,
  output logic cal_complete,
  output logic external_mode,
  output logic teaching,
  output logic start_ack,
  output logic in_operation,
  output logic cycle_end,
  output logic auto_mode,
  output logic cpu_healthy
);
  typedef struct packed {
    logic servo;
    logic cal_done;
    logic ext;
    logic teach;
    logic ack;
    logic inop;
    logic cend;
    logic auto_on;
    logic cal_pend;
    logic strobe_d;
    logic fail_d;
    logic pendantless;
    logic failure;
    logic [15:0] code;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [status_pkg::PIN_COUNT-1:0] pin_raw;
  logic [status_pkg::PIN_COUNT-1:0] pin_s;
  logic motor_req_s;
  logic cal_req_s;
  logic ext_req_s;
  logic strobe_s;
  logic stop_s;
  logic auto_en_s;
  logic start_req_s;
  logic inst_stop_s;
  logic step_stop_s;
  logic [1:0] panel_mode_s;
  logic [1:0] pendant_mode_s;
  logic health_s;

  logic [status_pkg::EVT_WIDTH-1:0] evt;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic addr_ok;
  logic strobe_rise;
  logic motor_ok;
  logic cal_ok;
  logic ext_ok;
  logic fail_rise;
  logic code_listed;
  logic ext_auto;
  logic servo_fail_drop;
  logic stop_all;
  logic panel_manual;
  logic pendant_manual;
  logic both_auto;

  assign pin_raw = {cpu_health, pendant_mode, panel_mode, all_step_stop, all_inst_stop,
                    program_start_request, auto_enable, robot_stop, prep_strobe,
                    external_mode_request, calibration_request, motor_power_request};

  // every pin passes two flops before any logic reads it
  pin_sync #(
    .WIDTH(status_pkg::PIN_COUNT)
  ) u_pin_sync (
    .core_clk(core_clk),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign motor_req_s = pin_s[0];
  assign cal_req_s = pin_s[1];
  assign ext_req_s = pin_s[2];
  assign strobe_s = pin_s[3];
  assign stop_s = pin_s[4];
  assign auto_en_s = pin_s[5];
  assign start_req_s = pin_s[6];
  assign inst_stop_s = pin_s[7];
  assign step_stop_s = pin_s[8];
  assign panel_mode_s = pin_s[10:9];
  assign pendant_mode_s = pin_s[12:11];
  assign health_s = pin_s[13];

  // function inputs must already stand when the strobe edge is seen
  assign strobe_rise = strobe_s && !state_r.strobe_d;
  assign motor_ok = strobe_rise && motor_req_s;
  assign cal_ok = strobe_rise && cal_req_s;
  assign ext_ok = strobe_rise && ext_req_s;

  assign fail_rise = state_r.failure && !state_r.fail_d;
  assign code_listed = ((state_r.code >= status_pkg::CODE_A_LO) &&
                        (state_r.code <= status_pkg::CODE_A_HI)) ||
                       ((state_r.code >= status_pkg::CODE_B_LO) &&
                        (state_r.code <= status_pkg::CODE_B_HI)) ||
                       (state_r.code == status_pkg::CODE_SINGLE);
  assign ext_auto = state_r.ext && state_r.auto_on;
  assign servo_fail_drop = fail_rise && (!code_listed || ext_auto);
  assign stop_all = stop_s || inst_stop_s || step_stop_s || evt[status_pkg::EVT_PANEL_STOP];
  assign panel_manual = (panel_mode_s == status_pkg::MODE_MANUAL) ||
                        (panel_mode_s == status_pkg::MODE_TEACH);
  assign pendant_manual = (pendant_mode_s == status_pkg::MODE_MANUAL) ||
                          (pendant_mode_s == status_pkg::MODE_TEACH);
  assign both_auto = (panel_mode_s == status_pkg::MODE_AUTO) &&
                     (pendant_mode_s == status_pkg::MODE_AUTO);

  assign addr_ok = hsel && hready && (htrans == status_pkg::HTRANS_NONSEQ);

  always_comb begin
    status_word = '0;
    status_word[status_pkg::ST_SERVO] = state_r.servo;
    status_word[status_pkg::ST_CAL] = state_r.cal_done;
    status_word[status_pkg::ST_EXT] = state_r.ext;
    status_word[status_pkg::ST_TEACH] = state_r.teach;
    status_word[status_pkg::ST_ACK] = state_r.ack;
    status_word[status_pkg::ST_INOP] = state_r.inop;
    status_word[status_pkg::ST_CEND] = state_r.cend;
    status_word[status_pkg::ST_CPU] = health_s;
    status_word[status_pkg::ST_AUTO] = state_r.auto_on;
    status_word[status_pkg::ST_CAL_PEND] = state_r.cal_pend;
    status_word[status_pkg::ST_START_PEND] = start_req_s && !state_r.ack;
    ctrl_word = '0;
    ctrl_word[status_pkg::CTRL_PENDANTLESS] = state_r.pendantless;
    ctrl_word[status_pkg::CTRL_FAILURE] = state_r.failure;
    ctrl_word[status_pkg::CTRL_CODE_LSB +: 16] = state_r.code;
  end

  always_comb begin
    state_nxt = state_r;
    evt = '0;
    // address phase; zero wait states, read data registered for the data phase
    state_nxt.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      state_nxt.wr_addr = haddr[7:0];
      if (!hwrite) begin
        unique case (haddr[7:0])
          status_pkg::CTRL_OFFS: state_nxt.rdata = ctrl_word;
          status_pkg::STATUS_OFFS: state_nxt.rdata = status_word;
          default: state_nxt.rdata = '0;
        endcase
      end
    end
    // data phase of a write
    if (state_r.wr_pend) begin
      if (state_r.wr_addr == status_pkg::CTRL_OFFS) begin
        state_nxt.pendantless = hwdata[status_pkg::CTRL_PENDANTLESS];
        state_nxt.failure = hwdata[status_pkg::CTRL_FAILURE];
        state_nxt.code = hwdata[status_pkg::CTRL_CODE_LSB +: 16];
      end else if (state_r.wr_addr == status_pkg::EVENT_OFFS) begin
        evt = hwdata[status_pkg::EVT_WIDTH-1:0];
      end
    end
    state_nxt.strobe_d = strobe_s;
    state_nxt.fail_d = state_r.failure;

    // servo: clears win, since a stop must never be overridden
    if (evt[status_pkg::EVT_MOTOR_ON] || motor_ok) begin
      state_nxt.servo = 1'b1;
    end
    if (stop_s || evt[status_pkg::EVT_MOTOR_OFF] || servo_fail_drop) begin
      state_nxt.servo = 1'b0;
    end

    // external calibration request waits for software; new request beats the clear
    if (evt[status_pkg::EVT_CAL_OK] || evt[status_pkg::EVT_CAL_FAIL]) begin
      state_nxt.cal_pend = 1'b0;
    end
    if (cal_ok) begin
      state_nxt.cal_pend = 1'b1;
    end
    if (evt[status_pkg::EVT_CAL_OK]) begin
      state_nxt.cal_done = 1'b1;
    end
    if (evt[status_pkg::EVT_CAL_FAIL]) begin
      state_nxt.cal_done = 1'b0;
    end

    // external mode; a step stop is deliberately absent from the clears
    if (ext_ok || evt[status_pkg::EVT_EXT_ON]) begin
      state_nxt.ext = 1'b1;
    end
    if (stop_s || fail_rise || evt[status_pkg::EVT_EXT_OFF]) begin
      state_nxt.ext = 1'b0;
    end
    if (!auto_en_s) begin
      state_nxt.ext = 1'b0;
    end
    if (state_r.ext && pendant_manual) begin
      state_nxt.ext = 1'b0;
    end

    // teaching holds its value while selectors say auto but auto-enable is off
    if (panel_manual || pendant_manual) begin
      state_nxt.teach = 1'b1;
    end else if (both_auto && auto_en_s) begin
      state_nxt.teach = 1'b0;
    end

    // auto mode ignores every stop request
    if (panel_manual || pendant_manual) begin
      state_nxt.auto_on = 1'b0;
    end else if (!auto_en_s && !state_r.pendantless) begin
      state_nxt.auto_on = 1'b0;
    end else if (both_auto) begin
      state_nxt.auto_on = 1'b1;
    end

    // four-phase start handshake
    if (evt[status_pkg::EVT_RUN] && start_req_s) begin
      state_nxt.ack = 1'b1;
    end
    if (!start_req_s) begin
      state_nxt.ack = 1'b0;
    end

    if (evt[status_pkg::EVT_RUN]) begin
      state_nxt.inop = 1'b1;
    end
    if (evt[status_pkg::EVT_IDLE] || stop_all) begin
      state_nxt.inop = 1'b0;
    end

    // end of any task sets it; pre-reading means motion may still be in progress
    if (evt[status_pkg::EVT_RUN]) begin
      state_nxt.cend = 1'b0;
    end
    if (evt[status_pkg::EVT_END]) begin
      state_nxt.cend = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = status_pkg::HRESP_OKAY;
  assign hrdata = state_r.rdata;
  assign servo_on = state_r.servo;
  assign cal_complete = state_r.cal_done;
  assign external_mode = state_r.ext;
  assign teaching = state_r.teach;
  assign start_ack = state_r.ack;
  assign in_operation = state_r.inop;
  assign cycle_end = state_r.cend;
  assign auto_mode = state_r.auto_on;
  // synchronised but not reset, so the health level is visible during reset
  assign cpu_healthy = health_s;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  servo_stop_drop_a: assert property (stop_s |=> !servo_on)
    else $error("servo-on stayed high after robot stop");
  servo_req_set_a: assert property (motor_ok && !stop_s && !servo_fail_drop &&
                                    !evt[status_pkg::EVT_MOTOR_OFF] |=> servo_on)
    else $error("servo-on not set by strobed motor request");
  servo_fail_drop_a: assert property (fail_rise && !code_listed |=> !servo_on)
    else $error("servo-on survived an unlisted failure");
  cal_fail_clear_a: assert property ($rose(cal_complete) |->
                                     $past(evt[status_pkg::EVT_CAL_OK] &&
                                           !evt[status_pkg::EVT_CAL_FAIL]))
    else $error("calibration complete set without a new success");
  cal_ok_set_a: assert property (evt[status_pkg::EVT_CAL_OK] &&
                                 !evt[status_pkg::EVT_CAL_FAIL] |=> cal_complete)
    else $error("calibration complete not set after success");
  ext_enable_drop_a: assert property (!auto_en_s |=> !external_mode)
    else $error("external mode kept with auto-enable off");
  ext_step_keep_a: assert property (external_mode && step_stop_s && !stop_s && !fail_rise &&
                                    auto_en_s && !pendant_manual &&
                                    !evt[status_pkg::EVT_EXT_OFF] |=> external_mode)
    else $error("external mode dropped by step stop");
  teach_manual_set_a: assert property (panel_manual || pendant_manual |=> teaching)
    else $error("teaching not set in manual mode");
  teach_clear_cond_a: assert property ($fell(teaching) |-> $past(both_auto && auto_en_s))
    else $error("teaching cleared without auto and auto-enable");
  ack_release_a: assert property (!start_req_s |=> !start_ack)
    else $error("start acknowledge held after request dropped");
  ack_cause_a: assert property ($rose(start_ack) |-> $past(evt[status_pkg::EVT_RUN] &&
                                                          start_req_s))
    else $error("start acknowledge without a run on request");
  inop_stop_a: assert property (stop_all |=> !in_operation)
    else $error("in-operation kept after stop-all");
  cend_run_a: assert property (evt[status_pkg::EVT_RUN] && !evt[status_pkg::EVT_END]
                               |=> !cycle_end)
    else $error("single-cycle end kept after program start");
  cend_end_a: assert property (evt[status_pkg::EVT_END] |=> cycle_end)
    else $error("single-cycle end not set on end");
  auto_drop_a: assert property ($fell(auto_mode) |-> $past(panel_manual || pendant_manual ||
                                (!auto_en_s && !state_r.pendantless)))
    else $error("auto mode dropped by a stop request");

  servo_ext_c: cover property (motor_ok ##1 servo_on);
  ext_mode_c: cover property (ext_ok ##1 external_mode);
  handshake_c: cover property ($rose(start_ack) ##[1:20] $fell(start_ack));
  cycle_c: cover property (evt[status_pkg::EVT_RUN] ##[1:50] cycle_end);
endmodule

// [dv/plc_model.sv]
`timescale 1ns/10ps
// far-side sequencer; every line it drives is a plain level with no pull
module plc_model (
  input wire logic core_clk,
  input wire logic start_ack,
  output logic motor_power_request,
  output logic calibration_request,
  output logic external_mode_request,
  output logic prep_strobe,
  output logic program_start_request
);
  initial begin
    motor_power_request = 1'b0;
    calibration_request = 1'b0;
    external_mode_request = 1'b0;
    prep_strobe = 1'b0;
    program_start_request = 1'b0;
  end

  // fn is {motor, calibration, external}; late raises the strobe first, so the request is stale
  task automatic prep(input logic [2:0] fn, input bit late);
    @(posedge core_clk);
    if (late) prep_strobe <= 1'b1;
    else {motor_power_request, calibration_request, external_mode_request} <= fn;
    repeat (3) @(posedge core_clk);
    if (late) {motor_power_request, calibration_request, external_mode_request} <= fn;
    else prep_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    prep_strobe <= 1'b0;
    {motor_power_request, calibration_request, external_mode_request} <= 3'h0;
    @(posedge core_clk);
  endtask

  // four-phase start: hold until acknowledge seen, then withdraw
  task automatic start(output bit ok);
    int i;
    @(posedge core_clk);
    program_start_request <= 1'b1;
    for (i = 0; i < 300 && start_ack !== 1'b1; i++) @(posedge core_clk);
    ok = (start_ack === 1'b1);
    program_start_request <= 1'b0;
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [31:0] lfsr = 32'hDD8DAFEF;
  logic [1:0] htrans, panel_mode, pendant_mode, m;
  logic [2:0] hsize;
  logic motor_power_request, calibration_request, external_mode_request, prep_strobe;
  logic robot_stop, auto_enable, program_start_request, all_inst_stop, all_step_stop;
  logic cpu_health, servo_on, cal_complete, external_mode, teaching, start_ack;
  logic in_operation, cycle_end, auto_mode, cpu_healthy;
  logic [8:0] outs, ev;
  logic [31:0] ctrl_a, stat_a;
  logic [79:0] code_list;
  int n_mismatch = 0;
  int tests_run = 0;
  bit ok;
  assign outs = {auto_mode, cpu_healthy, cycle_end, in_operation, start_ack, teaching,
    external_mode, cal_complete, servo_on};
  assign ctrl_a = {24'h0, status_pkg::CTRL_OFFS};
  assign stat_a = {24'h0, status_pkg::STATUS_OFFS};
  assign code_list = {status_pkg::CODE_A_LO, status_pkg::CODE_A_HI, status_pkg::CODE_B_LO,
    status_pkg::CODE_B_HI, status_pkg::CODE_SINGLE};
  always #4 core_clk = ~core_clk;

  system_status_output_logic u_dut (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .motor_power_request,
    .calibration_request, .external_mode_request, .prep_strobe, .robot_stop, .auto_enable,
    .program_start_request, .all_inst_stop, .all_step_stop, .panel_mode, .pendant_mode,
    .cpu_health, .servo_on, .cal_complete, .external_mode, .teaching, .start_ack,
    .in_operation, .cycle_end, .auto_mode, .cpu_healthy);
  plc_model u_plc (.core_clk, .start_ack, .motor_power_request, .calibration_request,
    .external_mode_request, .prep_strobe, .program_start_request);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // the bus never stalls today, but a wait state must not hang the run
  task automatic rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  task automatic bus(input bit wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= status_pkg::HTRANS_NONSEQ;
    rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  task automatic evt(input int b);
    bus(1'b1, {24'h0, status_pkg::EVENT_OFFS}, 32'h1 << b, q);
  endtask

  // only the pulsed line is touched, so back-to-back pulses never write one line twice
  task automatic pulse(input int s);
    for (int k = 0; k < 2; k++) begin
      case (s)
        0: all_inst_stop <= (k == 0);
        1: all_step_stop <= (k == 0);
        default: robot_stop <= (k == 0);
      endcase
      if (k == 0) repeat (4) @(posedge core_clk);
    end
  endtask

  // pins take three edges to reach the outputs, so five is settled
  task automatic see;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk("outputs", {23'h0, outs}, {23'h0, ev});
    bus(1'b0, stat_a, 32'h0, q);
    chk("status", {23'h0, q[8:0]}, {23'h0, ev});
  endtask

  task automatic sel(input logic [1:0] pm, input logic [1:0] pd, input logic ae);
    panel_mode <= pm;
    pendant_mode <= pd;
    auto_enable <= ae;
  endtask

  initial begin
    repeat (50000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    robot_stop = 1'b0;
    auto_enable = 1'b1;
    all_inst_stop = 1'b0;
    all_step_stop = 1'b0;
    panel_mode = status_pkg::MODE_AUTO;
    pendant_mode = status_pkg::MODE_AUTO;
    cpu_health = 1'b1;
    ev = 9'h0;
    ev[status_pkg::ST_CPU] = 1'b1;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset outputs", {23'h0, outs}, {23'h0, ev});
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    ev[status_pkg::ST_AUTO] = 1'b1;
    see;
    bus(1'b0, ctrl_a, 32'h0, q);
    chk("ctrl reset", q, status_pkg::CTRL_RESET);
    chk("hresp", {31'h0, hresp}, {31'h0, status_pkg::HRESP_OKAY});
    lfsr = lfsr_next(lfsr);
    bus(1'b1, {24'h0, 1'b1, lfsr[6:2], 2'h0}, lfsr, q);
    bus(1'b0, {24'h0, 1'b1, lfsr[6:2], 2'h0}, 32'h0, q);
    chk("unmapped", q, 32'h0);
    cpu_health <= 1'b0;
    ev[status_pkg::ST_CPU] = 1'b0;
    see;
    cpu_health <= 1'b1;
    ev[status_pkg::ST_CPU] = 1'b1;
    see;
    for (int j = 0; j < 4; j++) begin
      lfsr = lfsr_next(lfsr);
      m = j[0] ? status_pkg::MODE_TEACH : status_pkg::MODE_MANUAL;
      sel(j[1] ? status_pkg::MODE_AUTO : m, j[1] ? m : status_pkg::MODE_AUTO, lfsr[0]);
      ev[status_pkg::ST_TEACH] = 1'b1;
      ev[status_pkg::ST_AUTO] = 1'b0;
      see;
      sel(status_pkg::MODE_AUTO, status_pkg::MODE_AUTO, 1'b0);
      see;
      sel(status_pkg::MODE_AUTO, status_pkg::MODE_AUTO, 1'b1);
      ev[status_pkg::ST_TEACH] = 1'b0;
      ev[status_pkg::ST_AUTO] = 1'b1;
      see;
    end
    bus(1'b1, ctrl_a, 32'h1 << status_pkg::CTRL_PENDANTLESS, q);
    auto_enable <= 1'b0;
    see;
    auto_enable <= 1'b1;
    bus(1'b1, ctrl_a, 32'h0, q);
    pulse(0);
    pulse(1);
    see;
    u_plc.prep(3'b100, 1'b1);
    see;
    u_plc.prep(3'b100, 1'b0);
    ev[status_pkg::ST_SERVO] = 1'b1;
    see;
    pulse(2);
    ev[status_pkg::ST_SERVO] = 1'b0;
    see;
    evt(status_pkg::EVT_MOTOR_ON);
    ev[status_pkg::ST_SERVO] = 1'b1;
    see;
    evt(status_pkg::EVT_MOTOR_OFF);
    ev[status_pkg::ST_SERVO] = 1'b0;
    see;
    evt(status_pkg::EVT_MOTOR_ON);
    ev[status_pkg::ST_SERVO] = 1'b1;
    see;
    u_plc.prep(3'b010, 1'b0);
    bus(1'b0, stat_a, 32'h0, q);
    chk("cal pending", {31'h0, q[status_pkg::ST_CAL_PEND]}, 32'h1);
    evt(status_pkg::EVT_CAL_OK);
    ev[status_pkg::ST_CAL] = 1'b1;
    see;
    chk("cal pending clear", {31'h0, q[status_pkg::ST_CAL_PEND]}, 32'h0);
    evt(status_pkg::EVT_CAL_FAIL);
    ev[status_pkg::ST_CAL] = 1'b0;
    see;
    see;
    evt(status_pkg::EVT_CAL_OK);
    ev[status_pkg::ST_CAL] = 1'b1;
    see;
    u_plc.prep(3'b001, 1'b0);
    ev[status_pkg::ST_EXT] = 1'b1;
    see;
    pulse(1);
    see;
    evt(status_pkg::EVT_EXT_OFF);
    ev[status_pkg::ST_EXT] = 1'b0;
    see;
    evt(status_pkg::EVT_EXT_ON);
    ev[status_pkg::ST_EXT] = 1'b1;
    see;
    auto_enable <= 1'b0;
    ev[status_pkg::ST_EXT] = 1'b0;
    ev[status_pkg::ST_AUTO] = 1'b0;
    see;
    auto_enable <= 1'b1;
    ev[status_pkg::ST_AUTO] = 1'b1;
    u_plc.prep(3'b001, 1'b0);
    ev[status_pkg::ST_EXT] = 1'b1;
    see;
    pendant_mode <= status_pkg::MODE_MANUAL;
    ev[8:2] = 7'b0100010;
    see;
    pendant_mode <= status_pkg::MODE_AUTO;
    u_plc.prep(3'b001, 1'b0);
    ev[8:2] = 7'b1100001;
    see;
    bus(1'b1, ctrl_a, {status_pkg::CODE_A_HI, 16'h0002}, q);
    ev[status_pkg::ST_SERVO] = 1'b0;
    ev[status_pkg::ST_EXT] = 1'b0;
    see;
    bus(1'b0, ctrl_a, 32'h0, q);
    chk("ctrl readback", q, {status_pkg::CODE_A_HI, 16'h0002});
    bus(1'b1, ctrl_a, 32'h0, q);
    panel_mode <= status_pkg::MODE_MANUAL;
    evt(status_pkg::EVT_MOTOR_ON);
    ev[8:0] = 9'b010001011;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ctrl_a, {code_list[16 * (4 - i) +: 16], 16'h0002}, q);
      bus(1'b1, ctrl_a, 32'h0, q);
    end
    see;
    lfsr = lfsr_next(lfsr);
    bus(1'b1, ctrl_a, {4'h1, lfsr[11:0], 16'h0002}, q);
    ev[status_pkg::ST_SERVO] = 1'b0;
    see;
    bus(1'b1, ctrl_a, 32'h0, q);
    panel_mode <= status_pkg::MODE_AUTO;
    ev[8:0] = 9'b110000010;
    evt(status_pkg::EVT_RUN);
    ev[status_pkg::ST_INOP] = 1'b1;
    see;
    evt(status_pkg::EVT_END);
    ev[status_pkg::ST_CEND] = 1'b1;
    see;
    evt(status_pkg::EVT_RUN);
    ev[status_pkg::ST_CEND] = 1'b0;
    see;
    for (int s = 0; s < 4; s++) begin
      evt(status_pkg::EVT_RUN);
      if (s == 3) evt(status_pkg::EVT_PANEL_STOP);
      else pulse(s);
      ev[status_pkg::ST_INOP] = 1'b0;
      see;
    end
    evt(status_pkg::EVT_RUN);
    evt(status_pkg::EVT_END);
    evt(status_pkg::EVT_IDLE);
    ev[status_pkg::ST_CEND] = 1'b1;
    see;
    fork
      u_plc.start(ok);
      begin
        for (int i = 0; i < 20; i++) begin
          bus(1'b0, stat_a, 32'h0, q);
          if (q[status_pkg::ST_START_PEND] === 1'b1) break;
        end
        chk("start pending", {31'h0, q[status_pkg::ST_START_PEND]}, 32'h1);
        evt(status_pkg::EVT_RUN);
        @(negedge core_clk);
        chk("start_ack", {31'h0, start_ack}, 32'h1);
        chk("start request", {31'h0, program_start_request}, 32'h1);
      end
    join
    chk("handshake", {31'h0, ok}, 32'h1);
    ev[status_pkg::ST_INOP] = 1'b1;
    ev[status_pkg::ST_CEND] = 1'b0;
    see;
    tally_and_finish;
  end
endmodule
